// ==== contactless_rx_bit_collision_status_tb.sv ====
/*
  bench for crx_top: apb register checks, link states, framed reception with collisions.
  assumes: crx_pkg, crx_top, crx_monitor and crx_card compiled first.
*/
`default_nettype none
module contactless_rx_bit_collision_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] AS = crx_pkg::ADDR_LINK_STATUS;
  localparam logic [11:0] AB = crx_pkg::ADDR_RX_BIT_CTRL;
  localparam logic [11:0] AC = crx_pkg::ADDR_RX_COLL_POS;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, slow = 0, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, bv, bval, bc, busy, byv, cd, ie, ca, irq;
  logic [7:0] seq = 0, rb, rm;
  logic [6:0] nb = 0, cat = 0;
  logic [63:0] pat = 0;
  logic [15:0] lf = 16'h0013, k;
  logic [15:0] q[$];
  int err_count = 0, n_checks = 0, cyc = 0;
  initial forever #4 pclk = ~pclk;
  crx_top i_crx_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .tx_request(seq[0]), .tx_start(seq[1]), .tx_done(seq[2]), .rx_start(seq[3]), .rx_first_bit(seq[4]),
    .rx_done(seq[5]), .cmd_abort(seq[6]), .auth_success(seq[7]), .rx_bit_valid(bv), .rx_bit(bval),
    .rx_bit_coll(bc), .rx_byte_valid(byv), .rx_byte(rb), .rx_byte_mask(rm), .collision_detected(cd),
    .integrity_error(ie), .cipher_active(ca), .irq);
  crx_card i_crx_card (.pclk, .go, .slow, .nbits(nb), .coll_at(cat), .pat, .bit_valid(bv), .bit_val(bval),
    .bit_coll(bc), .busy);
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, x);
    end
  endtask
  // one apb transfer, held until ready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk(n < 50, 1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // sequencer pulse, then the reported state
  task automatic pulse(input int i, input logic [2:0] st);
    @(posedge pclk);
    seq <= 8'h01 << i;
    @(posedge pclk);
    seq <= 8'h00;
    apb(0, AS, 0);
    chk(r[2:0], st);
  endtask
  task automatic frame(input logic [2:0] al, input logic kp, nc, input logic [6:0] n, c, input logic [63:0] p);
    logic [127:0] s;
    logic [7:0] m;
    logic [15:0] mk;
    logic cl;
    int t;
    lf = lfsr(lf);
    mk = lf;
    cl = c < n;
    if (c < 64) p[c[5:0]] = 1'b0;
    apb(1, crx_pkg::ADDR_IRQ_MASK, {29'h0, mk[2:0]});
    apb(1, AB, {24'h0, kp, al, nc, 3'h0});
    pulse(0, crx_pkg::ST_TX_WAIT);
    pulse(1, crx_pkg::ST_TRANSMIT);
    pulse(2, crx_pkg::ST_RX_WAIT);
    pulse(3, crx_pkg::ST_WAIT_DATA);
    apb(0, AB, 0);
    chk(r[2:0], 0);
    pulse(4, crx_pkg::ST_RECEIVE);
    @(posedge pclk);
    {nb, cat, pat, go, slow} <= {n, c, p, 1'b1, mk[3]};
    @(posedge pclk);
    go <= 1'b0;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (busy !== 1'b0 && t < 400);
    chk(t < 400, 1);
    pulse(5, crx_pkg::ST_IDLE);
    s = 0;
    for (t = 0; t < n; t++) s[al + t] = (!kp && cl && t >= c) ? 1'b0 : p[t];
    for (t = 0; t * 8 < al + n; t++) begin
      for (int b = 0; b < 8; b++) m[b] = t * 8 + b >= al && t * 8 + b < al + n;
      k = (q.size() > 0) ? q.pop_front() : 16'h0;
      chk({k[15:8], k[7:0] & m}, {m, s[t * 8 +: 8] & m});
    end
    chk(q.size(), 0);
    apb(0, AC, 0);
    chk(r[7], cl && c + al <= 63);
    if (r[7] === 1'b1) chk(r[6:0], c + al);
    apb(0, AB, 0);
    chk(r[2:0], (al != 0) ? (al + n) % 8 : 0);
    chk({cd, ie}, {cl, cl && nc});
    chk(irq, (cl & mk[0]) | (cl & nc & mk[1]) | mk[2]);
    apb(1, crx_pkg::ADDR_IRQ_STATUS, 32'h7);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
  endtask
  // bytes toward storage, and the hang limit
  always @(posedge pclk) begin
    cyc++;
    if (byv === 1'b1) q.push_back({rm, rb});
    if (cyc == 40000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, AB, 0);
    chk(r, 32'h80);
    apb(1, AS, 32'hFF);
    apb(0, AS, 0);
    chk(r, 0);
    apb(1, 12'hFFC, 32'h1);
    chk(e, 1);
    @(posedge pclk);
    seq <= 8'h80;
    @(posedge pclk);
    seq <= 8'h00;
    apb(0, AS, 0);
    chk(r, 32'h20);
    apb(1, AS, 0);
    repeat (3) @(posedge pclk);
    chk(ca, 0);
    pulse(0, crx_pkg::ST_TX_WAIT);
    pulse(6, crx_pkg::ST_IDLE);
    frame(0, 1, 0, 16, 127, 64'hA5C3);
    frame(7, 0, 1, 20, 0, 64'hFFFFF);
    frame(4, 0, 0, 12, 3, 64'hFFF);
    frame(7, 1, 1, 64, 60, '1);
    repeat (8) begin
      lf = lfsr(lf);
      k = lf;
      lf = lfsr(lf);
      frame(k[2:0], k[3], k[4], {1'b0, k[10:5]} + 7'h01, lf[6:0], {4{lf}});
    end
    tally_and_finish();
  end
endmodule // contactless_rx_bit_collision_status_tb
`default_nettype wire

// ==== crx_card.sv ====
/*
  crx_card: card in the field, sends a bit frame with an optional collided bit.
  assumes: go is a one cycle pulse; pattern and counts stay still while busy.
*/
`default_nettype none
module crx_card (
  // control
  input wire logic pclk,
  input wire logic go,
  input wire logic slow,
  input wire logic [6:0] nbits,
  input wire logic [6:0] coll_at,
  input wire logic [63:0] pat,
  // decoder side
  output logic bit_valid = 1'b0,
  output logic bit_val = 1'b0,
  output logic bit_coll = 1'b0,
  output logic busy = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] idx = 7'h00;
  logic gap = 1'b0;
  // slow cards leave a gap so the decoder sees sparse strobes
  always @(posedge pclk) begin
    bit_valid <= 1'b0;
    bit_coll <= 1'b0;
    if (go) begin
      busy <= 1'b1;
      idx <= 7'h00;
    end else if (busy && gap) begin
      gap <= 1'b0;
    end else if (busy && idx == nbits) begin
      busy <= 1'b0;
    end else if (busy) begin
      bit_valid <= 1'b1;
      bit_val <= pat[idx[5:0]];
      bit_coll <= idx == coll_at;
      idx <= idx + 7'h01;
      gap <= slow;
    end else begin
      bit_val <= ~bit_val; // idle line toggles, never a stale value
    end
  end
endmodule // crx_card
`default_nettype wire

// ==== crx_monitor.sv ====
/*
  crx_monitor: concurrent checks on the ports of crx_top.
  assumes: bound into crx_top; pclk single domain, presetn async low.
*/
`default_nettype none
module crx_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // sequencer and decoder
  input wire logic rx_start,
  input wire logic rx_done,
  input wire logic auth_success,
  input wire logic rx_bit_valid,
  input wire logic rx_bit_coll,
  // results
  input wire logic rx_byte_valid,
  input wire logic collision_detected,
  input wire logic integrity_error,
  input wire logic cipher_active,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // apb answers in the access phase, one cycle only
  apb_answer_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  // flags need a collided bit or authentication as cause and clear at reception start; bytes need a bit
  coll_cause_a: assert property ($rose(collision_detected) |-> $past(rx_bit_valid && rx_bit_coll))
    else $error("collision flag without collided bit");
  integ_cause_a: assert property ($rose(integrity_error) |-> $past(rx_bit_valid && rx_bit_coll))
    else $error("integrity flag without collision");
  flag_clear_a: assert property (rx_start |=> !collision_detected && !integrity_error)
    else $error("flags survive reception start");
  cipher_set_a: assert property ($rose(cipher_active) |-> $past(auth_success))
    else $error("cipher on without authentication");
  byte_cause_a: assert property (rx_byte_valid |-> $past(rx_bit_valid || rx_done)
    || $past(rx_bit_valid || rx_done, 2)) else $error("byte without bit");
  // main scenarios
  cov_coll_c: cover property ($rose(collision_detected));
  cov_err_c: cover property (pslverr);
  cov_irq_c: cover property ($fell(irq));
endmodule // crx_monitor
bind crx_top crx_monitor i_crx_monitor (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .rx_start,
  .rx_done, .auth_success, .rx_bit_valid, .rx_bit_coll, .rx_byte_valid, .collision_detected,
  .integrity_error, .cipher_active, .irq);
`default_nettype wire

// ==== crx_pkg.sv ====
/*
  crx_pkg: constants and types shared by the contactless receive bit and collision status block.
  assumes: included before crx_top and crx_regs; all users refer to names as crx_pkg::name.
*/
// Behaviour
// - bit 5 of the status register shows whether the card cipher is on, and a software clear switches it off.
// - only the card authentication command sets the cipher-on bit; writing a one does nothing.
// - the link state field codes are 000 idle, 001 transmit wait, 011 transmitting, 101 receive wait, 110 wait for data, 111 receiving, never 100.
// - with bit 7 of the receive bit control clear, every bit after a collision is stored as zero.
// - the first received bit lands at the alignment position and later bits follow, carrying into bit 0 of the next byte.
// - reception is byte oriented for alignment zero and bit oriented otherwise.
// - with the collision-as-integrity-error bit 3 set, each collision also raises the integrity error flag.
// - the last-byte field gives the valid bits of the final byte in bit oriented reception, zero meaning all eight.
// - the decoder writes the last-byte count at the end of a bit oriented frame and clears it when reception starts.
// - the collision position valid bit is set only for a meaningful position, clear for no collision or out of range.
// - the collision position is the zero based bit position of the first collided bit in the received bytes, counted from bit 0 of the first byte.
// - positions are reported only within the first eight bytes, up to 3F.
// - a nonzero alignment is added into the reported collision position.
// - a collision sets the collision detected flag and records the first collision position.
`default_nettype none
package crx_pkg;
  // register indices; the byte address on the bus is the index times four
  localparam logic [7:0] IDX_LINK_STATUS = 8'h0B;
  localparam logic [7:0] IDX_RX_BIT_CTRL = 8'h0C;
  localparam logic [7:0] IDX_RX_COLL_POS = 8'h0D;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
  localparam logic [11:0] ADDR_LINK_STATUS = {2'h0, IDX_LINK_STATUS, 2'h0};
  localparam logic [11:0] ADDR_RX_BIT_CTRL = {2'h0, IDX_RX_BIT_CTRL, 2'h0};
  localparam logic [11:0] ADDR_RX_COLL_POS = {2'h0, IDX_RX_COLL_POS, 2'h0};
  localparam logic [11:0] ADDR_IRQ_STATUS = {2'h0, IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] ADDR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};
  // field positions
  localparam int CIPHER_BIT = 5;
  localparam int KEEP_BIT = 7;
  localparam int ALIGN_LSB = 4;
  localparam int COLLISION_AS_INTEGRITY_ERROR_BIT = 3;
  localparam int VALID_BIT = 7;
  // interrupt status bits
  localparam int IRQ_COLL = 0;
  localparam int IRQ_INTEG = 1;
  localparam int IRQ_RXDONE = 2;
  localparam int IRQ_W = 3;
  // reset values
  localparam logic [7:0] RST_RX_BIT_CTRL = 8'h80;
  localparam logic [7:0] RST_RX_COLL_POS = 8'h00;
  localparam logic [6:0] COLL_POS_MAX = 7'h3F;
  localparam logic [2:0] ALIGN_BYTE = 3'h0;
  // link state codes
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_TX_WAIT = 3'b001,
    ST_TRANSMIT = 3'b011,
    ST_RX_WAIT = 3'b101,
    ST_WAIT_DATA = 3'b110,
    ST_RECEIVE = 3'b111
  } crx_state_t;
endpackage : crx_pkg
`default_nettype wire

// ==== crx_regs.sv ====
/*
  crx_regs: apb slave decode and register storage for the status, bit control, collision and interrupt registers.
  assumes: one clock pclk, asynchronous active low presetn; event inputs come from logic on the same clock.
*/
`default_nettype none
module crx_regs (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core state
  input wire logic [2:0] link_state,
  input wire logic cipher_active,
  input wire logic [7:0] coll_reg,
  input wire logic [2:0] last_bits_hw,
  input wire logic last_bits_load,
  input wire logic [2:0] irq_events,
  // software fields
  output logic [7:0] bit_ctrl,
  output logic cipher_clear,
  output logic irq
);
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] bit_ctrl;
    logic cipher_clear;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic irq;
  } crx_regs_t;
  crx_regs_t cur, next_cur;
  logic setup, wr;

  // no wait state: answer in the first access cycle after setup
  always_comb begin
    next_cur = cur;
    setup = psel && !penable;
    // writes land at the edge where ready is sampled high, never earlier
    wr = psel && penable && pwrite && cur.pready;
    next_cur.pready = setup;
    next_cur.pslverr = 1'b0;
    next_cur.prdata = 32'h0;
    next_cur.cipher_clear = 1'b0;
    if (setup || wr) begin
      unique case (paddr)
        crx_pkg::ADDR_LINK_STATUS: begin
          if (setup) next_cur.prdata = {26'h0, cipher_active, 2'h0, link_state};
          if (wr && !pwdata[crx_pkg::CIPHER_BIT]) next_cur.cipher_clear = 1'b1;
        end
        crx_pkg::ADDR_RX_BIT_CTRL: begin
          if (setup) next_cur.prdata = {24'h0, cur.bit_ctrl};
          if (wr) next_cur.bit_ctrl = pwdata[7:0];
        end
        crx_pkg::ADDR_RX_COLL_POS: if (setup) next_cur.prdata = {24'h0, coll_reg};
        crx_pkg::ADDR_IRQ_STATUS: if (setup) next_cur.prdata = {29'h0, cur.irq_status};
        crx_pkg::ADDR_IRQ_MASK: begin
          if (setup) next_cur.prdata = {29'h0, cur.irq_mask};
          if (wr) next_cur.irq_mask = pwdata[2:0];
        end
        default: if (setup) next_cur.pslverr = 1'b1; // unmapped address, nothing written
      endcase
    end
    // decoder result overrides a same cycle software write
    if (last_bits_load) next_cur.bit_ctrl[2:0] = last_bits_hw;
    // write one to clear, a new event wins over the clear
    if (wr && paddr == crx_pkg::ADDR_IRQ_STATUS) next_cur.irq_status = cur.irq_status & ~pwdata[2:0];
    next_cur.irq_status = next_cur.irq_status | irq_events;
    next_cur.irq = |(next_cur.irq_status & next_cur.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
      cur.bit_ctrl <= crx_pkg::RST_RX_BIT_CTRL;
    end else begin
      cur <= next_cur;
    end
  end

  assign prdata = cur.prdata;
  assign pready = cur.pready;
  assign pslverr = cur.pslverr;
  assign bit_ctrl = cur.bit_ctrl;
  assign cipher_clear = cur.cipher_clear;
  assign irq = cur.irq;
endmodule // crx_regs
`default_nettype wire

// ==== crx_top.sv ====
/*
  crx_top: receive bit framing, collision recording and link state reporting for a contactless reader.
  assumes: decoder strobes are synchronous to pclk; a command sequencer drives the start and phase inputs.
*/
// The implementer's own choice: register access over APB.
`default_nettype none
module crx_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // command sequencer phases, one cycle pulses
  input wire logic tx_request,
  input wire logic tx_start,
  input wire logic tx_done,
  input wire logic rx_start,
  input wire logic rx_first_bit,
  input wire logic rx_done,
  input wire logic cmd_abort,
  input wire logic auth_success,
  // receive decoder bit stream
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic rx_bit_coll,
  // received bytes toward storage
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic [7:0] rx_byte_mask,
  // flags and interrupt
  output logic collision_detected,
  output logic integrity_error,
  output logic cipher_active,
  output logic irq
);
  typedef struct packed {
    crx_pkg::crx_state_t state;
    logic cipher;
    logic [7:0] shift;
    logic [7:0] mask;
    logic [2:0] pos;
    logic [6:0] bit_idx;
    logic in_coll;
    logic coll_seen;
    logic [7:0] coll_reg;
    logic byte_valid;
    logic [7:0] byte_out;
    logic [7:0] byte_mask;
    logic coll_flag;
    logic integ_flag;
    logic [2:0] last_bits;
    logic last_load;
    logic [2:0] events;
  } crx_core_t;
  crx_core_t cur, next_cur;
  logic [7:0] bit_ctrl;
  logic cipher_clear;
  logic keep_after;
  logic [2:0] align;
  logic bit_mode;
  logic stored_bit;
  logic [7:0] abs_idx;

  crx_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .link_state(cur.state),
    .cipher_active(cur.cipher),
    .coll_reg(cur.coll_reg),
    .last_bits_hw(cur.last_bits),
    .last_bits_load(cur.last_load),
    .irq_events(cur.events),
    .bit_ctrl(bit_ctrl),
    .cipher_clear(cipher_clear),
    .irq(irq)
  );

  assign keep_after = bit_ctrl[crx_pkg::KEEP_BIT];
  assign align = bit_ctrl[crx_pkg::ALIGN_LSB +: 3];
  assign bit_mode = (align != crx_pkg::ALIGN_BYTE);

  // main framing process
  always_comb begin
    next_cur = cur;
    next_cur.byte_valid = 1'b0;
    next_cur.last_load = 1'b0;
    next_cur.events = 3'h0;
    stored_bit = rx_bit;
    abs_idx = {1'b0, cur.bit_idx} + {5'h0, align};

    // link state machine
    unique case (cur.state)
      crx_pkg::ST_IDLE: if (tx_request) next_cur.state = crx_pkg::ST_TX_WAIT;
      crx_pkg::ST_TX_WAIT: if (tx_start) next_cur.state = crx_pkg::ST_TRANSMIT;
      crx_pkg::ST_TRANSMIT: if (tx_done) next_cur.state = crx_pkg::ST_RX_WAIT;
      crx_pkg::ST_RX_WAIT: if (rx_start) next_cur.state = crx_pkg::ST_WAIT_DATA;
      crx_pkg::ST_WAIT_DATA: if (rx_first_bit) next_cur.state = crx_pkg::ST_RECEIVE;
      crx_pkg::ST_RECEIVE: if (rx_done) next_cur.state = crx_pkg::ST_IDLE;
      default: next_cur.state = crx_pkg::ST_IDLE; // code 100 never held
    endcase
    if (cmd_abort) next_cur.state = crx_pkg::ST_IDLE;

    // cipher: set only by authentication, cleared by software
    if (cipher_clear) next_cur.cipher = 1'b0;
    if (auth_success) next_cur.cipher = 1'b1;

    // start of receive phase clears per frame state
    if (rx_start) begin
      next_cur.pos = align;
      next_cur.shift = 8'h00;
      next_cur.mask = 8'h00;
      next_cur.bit_idx = 7'h00;
      next_cur.in_coll = 1'b0;
      next_cur.coll_seen = 1'b0;
      next_cur.coll_reg = crx_pkg::RST_RX_COLL_POS;
      next_cur.coll_flag = 1'b0;
      next_cur.integ_flag = 1'b0;
      next_cur.last_bits = 3'h0;
      next_cur.last_load = 1'b1;
    end else if (rx_bit_valid && cur.state == crx_pkg::ST_RECEIVE) begin
      // zero fill after a collision unless told to keep values
      if ((cur.in_coll || rx_bit_coll) && !keep_after) stored_bit = 1'b0;
      next_cur.shift[cur.pos] = stored_bit;
      next_cur.mask[cur.pos] = 1'b1;
      next_cur.pos = cur.pos + 3'h1; // wraps into bit 0 of next byte
      if (cur.bit_idx != 7'h7F) next_cur.bit_idx = cur.bit_idx + 7'h01;
      if (rx_bit_coll) begin
        next_cur.in_coll = 1'b1;
        next_cur.coll_flag = 1'b1;
        next_cur.events[crx_pkg::IRQ_COLL] = 1'b1;
        if (bit_ctrl[crx_pkg::COLLISION_AS_INTEGRITY_ERROR_BIT]) begin
          next_cur.integ_flag = 1'b1;
          next_cur.events[crx_pkg::IRQ_INTEG] = 1'b1;
        end
        // only the first collision of the frame is recorded
        if (!cur.coll_seen) begin
          next_cur.coll_seen = 1'b1;
          if (abs_idx <= {1'b0, crx_pkg::COLL_POS_MAX}) begin
            next_cur.coll_reg = {1'b1, abs_idx[6:0]};
          end
        end
      end
      if (cur.pos == 3'h7) begin
        next_cur.byte_valid = 1'b1;
        next_cur.byte_out = next_cur.shift;
        next_cur.byte_mask = next_cur.mask;
        next_cur.shift = 8'h00;
        next_cur.mask = 8'h00;
      end
    end

    // end of frame: flush a partial byte and, in bit oriented mode only, report its valid bits
    if (rx_done && cur.state == crx_pkg::ST_RECEIVE) begin
      next_cur.events[crx_pkg::IRQ_RXDONE] = 1'b1;
      if (cur.mask != 8'h00) begin
        next_cur.byte_valid = 1'b1;
        next_cur.byte_out = cur.shift;
        next_cur.byte_mask = cur.mask;
      end
      if (bit_mode) begin
        next_cur.last_bits = cur.pos;
        next_cur.last_load = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
      cur.state <= crx_pkg::ST_IDLE;
    end else begin
      cur <= next_cur;
    end
  end

  assign rx_byte_valid = cur.byte_valid;
  assign rx_byte = cur.byte_out;
  assign rx_byte_mask = cur.byte_mask;
  assign collision_detected = cur.coll_flag;
  assign integrity_error = cur.integ_flag;
  assign cipher_active = cur.cipher;
endmodule // crx_top
`default_nettype wire
